// *** include/dmsa_consts.vh ***
`ifndef DMSA_CONSTS_VH
`define DMSA_CONSTS_VH
`define DMSA_CLK_NS            10
`define DMSA_PAUSE_NS          200000
`define DMSA_INIT_CYCLES       4'h8
`define DMSA_REFRESH_ROWS      512
`define DMSA_REFRESH_NS        8200000
`define DMSA_ROW_ACCESS_NS     100
`define DMSA_COL_ACCESS_NS     30
`define DMSA_ADDR_ACCESS_NS    50
`define DMSA_OUT_TURNOFF_NS    25
`define DMSA_ROW_HOLD_NS       15
`define DMSA_DATA_HOLD_NS      15
`define DMSA_WR_ROW_LEAD_NS    25
`define DMSA_WR_COL_LEAD_NS    20
`define DMSA_ROW_PRECHARGE_NS  70
`define DMSA_ROW_PULSE_NS      100
`define DMSA_COL_PULSE_NS      30
`define DMSA_CAS_SETUP_RFSH_NS 10
`define DMSA_CAS_HOLD_RFSH_NS  15
`define DMSA_CYC_UP(ns)   (((ns) + `DMSA_CLK_NS - 1) / `DMSA_CLK_NS)
`endif

// *** logic/dmsa_timer.v ***
`default_nettype none
module dmsa_timer (
  input  wire        sys_clk,
  input  wire        rst,
  input  wire        load,
  input  wire [24:0] load_value,
  output reg         done
);
  reg [24:0] count;
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count <= 25'h0000000;
      done  <= 1'b1;
    end else if (load) begin
      count <= load_value;
      done  <= (load_value == 25'h0000000);
    end else if (count != 25'h0000000) begin
      count <= count - 25'h0000001;
      done  <= (count == 25'h0000001);
    end
  end
endmodule // dmsa_timer
`default_nettype wire

// *** logic/dmsa_ctrl.v ***
`include "dmsa_consts.vh"
`default_nettype none
module dmsa_ctrl #(
  parameter [24:0] PAUSE_CYCLES   = `DMSA_CYC_UP(`DMSA_PAUSE_NS),
  parameter [24:0] REFRESH_CYCLES = (`DMSA_REFRESH_NS / `DMSA_REFRESH_ROWS) / `DMSA_CLK_NS,
  parameter        USE_CBR        = 1'b1
) (
  input  wire        sys_clk,
  input  wire        rst,
  input  wire        req_valid,
  input  wire        req_write,
  input  wire [19:0] req_addr,
  input  wire [7:0]  req_wdata,
  output reg         req_ready,
  output reg         rsp_valid,
  output reg  [7:0]  rsp_rdata,
  output reg         init_done,
  output reg  [9:0]  shared_address_pins,
  output reg         row_strobe_n,
  output reg         column_strobe_n,
  output reg         write_select_n,
  output reg  [7:0]  data_out,
  output reg         data_oe,
  input  wire [7:0]  data_in
);
  localparam [3:0] ST_PAUSE = 4'h0, ST_INIT = 4'h1, ST_IDLE = 4'h2, ST_ROW = 4'h3, ST_COL = 4'h4,
                   ST_END = 4'h5, ST_PRE = 4'h6, ST_RF_CAS = 4'h7, ST_RF_RAS = 4'h8;
  localparam [24:0] T_ROWHOLD = `DMSA_CYC_UP(`DMSA_ROW_HOLD_NS);
  localparam [24:0] T_ACCESS  = `DMSA_CYC_UP(`DMSA_ROW_ACCESS_NS + 2 * `DMSA_CLK_NS);
  localparam [24:0] T_COLLOW  = `DMSA_CYC_UP(`DMSA_WR_ROW_LEAD_NS + `DMSA_DATA_HOLD_NS + `DMSA_COL_PULSE_NS);
  localparam [24:0] T_ROWTAIL = `DMSA_CYC_UP(`DMSA_ROW_PULSE_NS);
  localparam [24:0] T_PRE     = `DMSA_CYC_UP(`DMSA_ROW_PRECHARGE_NS + `DMSA_OUT_TURNOFF_NS);
  localparam [24:0] T_CASSU   = `DMSA_CYC_UP(`DMSA_CAS_SETUP_RFSH_NS);
  reg [3:0]  state;
  reg [3:0]  init_count;
  reg        cur_write;
  reg        refresh_due;
  reg [24:0] refresh_count;
  reg [7:0]  data_sync1;
  reg [7:0]  data_sync2;
  reg        load;
  reg [24:0] load_value;
  wire       timer_done;
  dmsa_timer u_timer (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .load       (load),
    .load_value (load_value),
    .done       (timer_done)
  );
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      data_sync1 <= 8'h00;
      data_sync2 <= 8'h00;
    end else begin
      data_sync1 <= data_in;
      data_sync2 <= data_sync1;
    end
  end
  // refresh pacing runs from the start; set wins over the clear at refresh issue
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      refresh_count <= 25'h0000000;
      refresh_due   <= 1'b0;
    end else if (refresh_count == REFRESH_CYCLES - 25'h0000001) begin
      refresh_count <= 25'h0000000;
      refresh_due   <= 1'b1;
    end else begin
      refresh_count <= refresh_count + 25'h0000001;
      if (state == ST_RF_CAS && timer_done)
        refresh_due <= 1'b0;
    end
  end
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state               <= ST_PAUSE;
      init_count          <= 4'h0;
      cur_write           <= 1'b0;
      load                <= 1'b1;
      load_value          <= PAUSE_CYCLES;
      req_ready           <= 1'b0;
      rsp_valid           <= 1'b0;
      rsp_rdata           <= 8'h00;
      init_done           <= 1'b0;
      shared_address_pins <= 10'h000;
      row_strobe_n        <= 1'b1;
      column_strobe_n     <= 1'b1;
      write_select_n      <= 1'b1;
      data_out            <= 8'h00;
      data_oe             <= 1'b0;
    end else begin
      load      <= 1'b0;
      rsp_valid <= 1'b0;
      req_ready <= 1'b0;
      case (state)
        ST_PAUSE: if (!load && timer_done) begin
          state <= ST_INIT;
        end
        ST_INIT: begin
          if (init_count == `DMSA_INIT_CYCLES) begin
            init_done <= 1'b1;
            state     <= ST_IDLE;
          end else begin
            init_count <= init_count + 4'h1;
            if (USE_CBR) begin
              column_strobe_n <= 1'b0;
              load <= 1'b1;
              load_value <= T_CASSU;
              state <= ST_RF_CAS;
            end else begin
              shared_address_pins <= {6'h00, init_count};
              load <= 1'b1;
              load_value <= T_ROWHOLD;
              state <= ST_ROW;
              cur_write <= 1'b0;
            end
          end
        end
        ST_IDLE: begin
          if (refresh_due) begin
            column_strobe_n <= 1'b0;
            load <= 1'b1;
            load_value <= T_CASSU;
            state <= ST_RF_CAS;
          end else if (req_valid) begin
            req_ready           <= 1'b1;
            cur_write           <= req_write;
            write_select_n      <= !req_write;
            data_out            <= req_wdata;
            data_oe             <= req_write;
            shared_address_pins <= req_addr[19:10];
            state               <= ST_ROW;
            load                <= 1'b1;
            load_value          <= T_ROWHOLD;
          end
        end
        ST_ROW: begin
          if (row_strobe_n) begin
            row_strobe_n <= 1'b0;
          end else if (!load && timer_done) begin
            if (!init_done) begin
              load <= 1'b1;
              load_value <= T_ROWTAIL;
              state <= ST_END;
            end else begin
              shared_address_pins <= req_addr_hold(shared_address_pins);
              state <= ST_COL;
            end
          end
        end
        ST_COL: begin
          if (column_strobe_n) begin
            column_strobe_n <= 1'b0;
            load <= 1'b1;
            load_value <= cur_write ? T_COLLOW : T_ACCESS;
          end else if (!load && timer_done) begin
            if (!cur_write) begin
              rsp_rdata <= data_sync2;
              rsp_valid <= 1'b1;
            end
            column_strobe_n <= 1'b1;
            row_strobe_n    <= 1'b1;
            state <= ST_END;
            load <= 1'b1;
            load_value <= 25'h0000000;
          end
        end
        ST_END: if (!load && timer_done) begin
          row_strobe_n    <= 1'b1;
          column_strobe_n <= 1'b1;
          write_select_n  <= 1'b1;
          data_oe         <= 1'b0;
          load <= 1'b1;
          load_value <= T_PRE;
          state <= ST_PRE;
        end
        ST_PRE: if (!load && timer_done) begin
          state <= init_done ? ST_IDLE : ST_INIT;
        end
        ST_RF_CAS: if (!load && timer_done) begin
          row_strobe_n <= 1'b0;
          load <= 1'b1;
          load_value <= T_ROWTAIL;
          state <= ST_RF_RAS;
        end
        ST_RF_RAS: if (!load && timer_done) begin
          state <= ST_END;
          load <= 1'b1;
          load_value <= 25'h0000000;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
  reg [9:0] col_addr;
  always @(posedge sys_clk or posedge rst) begin
    if (rst)
      col_addr <= 10'h000;
    else if (state == ST_IDLE && req_valid && !refresh_due)
      col_addr <= req_addr[9:0];
  end
  function [9:0] req_addr_hold;
    input [9:0] unused_row;
    begin
      req_addr_hold = col_addr ^ (unused_row & 10'h000);
    end
  endfunction
endmodule // dmsa_ctrl
`default_nettype wire

// *** dv/dmsa_chk.sv ***
`default_nettype none
module dmsa_chk #(
  parameter [24:0] REFRESH_CYCLES = 25'h641
) (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        req_write,
  input wire logic [19:0] req_addr,
  input wire logic        req_ready,
  input wire logic        init_done,
  input wire logic [9:0]  shared_address_pins,
  input wire logic        row_strobe_n,
  input wire logic        column_strobe_n,
  input wire logic        write_select_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [24:0] gap;
  logic [19:0] addr_q;
  logic        wr_q;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // slack allows one access in flight when a refresh falls due
  always @(posedge sys_clk or posedge rst) begin
    if (rst) gap <= 25'h0;
    else if ($fell(row_strobe_n) && !column_strobe_n) gap <= 25'h0;
    else gap <= gap + 25'h1;
  end
  // copy of the taken request: the bench may move its fields once ready has been seen
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      addr_q <= 20'h00000;
      wr_q   <= 1'b0;
    end else if (req_ready) begin
      addr_q <= req_addr;
      wr_q   <= req_write;
    end
  end
  a_ready_after_init: assert property (req_ready |-> init_done)
    else $error("request taken before init");
  a_row_addr: assert property ($fell(row_strobe_n) && column_strobe_n && init_done
    |-> shared_address_pins == addr_q[19:10] ##1 shared_address_pins == addr_q[19:10])
    else $error("bad row address");
  a_col_addr_type: assert property ($fell(column_strobe_n) && !row_strobe_n
    |-> shared_address_pins == addr_q[9:0] && write_select_n == !wr_q)
    else $error("bad column address or cycle type");
  a_read_we_high: assert property (!row_strobe_n && write_select_n |=> write_select_n || row_strobe_n)
    else $error("write select fell in read");
  a_wr_row_lead: assert property ($rose(row_strobe_n) && !$past(write_select_n) |-> !$past(write_select_n, 3))
    else $error("short write lead to row rise");
  a_wr_col_lead: assert property ($rose(column_strobe_n) && !$past(write_select_n) |-> !$past(write_select_n, 2))
    else $error("short write lead to column rise");
  a_read_hold: assert property ($rose(column_strobe_n) && $past(write_select_n) |-> write_select_n)
    else $error("read hold missed");
  a_refresh_gap: assert property (init_done |-> gap < REFRESH_CYCLES + 25'h40)
    else $error("refresh interval exceeded");
endmodule // dmsa_chk

bind dmsa_ctrl dmsa_chk #(.REFRESH_CYCLES(REFRESH_CYCLES)) u_chk (.sys_clk, .rst, .req_write, .req_addr,
  .req_ready, .init_done, .shared_address_pins, .row_strobe_n, .column_strobe_n, .write_select_n);
`default_nettype wire

// *** dv/dmsa_mem.sv ***
`default_nettype none
module dmsa_mem (
  input wire logic [9:0] addr,
  input wire logic       ras_n,
  input wire logic       cas_n,
  input wire logic       we_n,
  input wire logic [7:0] din,
  output var logic [7:0] dq,
  output var int         cbr_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  mem [bit [19:0]];
  logic [9:0]  row;
  logic [19:0] a;
  realtime     t_ras, t_adr, t_cup, t_ok;
  // a floating bus flips every bit 7 ns after each column strobe rise, so it does not keep the byte it held before the rise
  initial begin
    dq = 8'hA5;
    cbr_n = 0;
  end
  always @(addr) t_adr = $realtime;
  always @(negedge ras_n) begin
    t_ras = $realtime;
    if (cas_n) row = addr;
    else cbr_n++;
  end
  always @(negedge cas_n) begin
    if (!ras_n) begin
      a = {row, addr};
      if (!we_n) mem[a] = din;
      else begin
        // the pins show the wrong byte until the access completes, so an early sample fails
        dq = ~mem[a];
        t_ok = t_ras + 100;
        if ($realtime + 30 > t_ok) t_ok = $realtime + 30;
        if (t_adr + 50 > t_ok) t_ok = t_adr + 50;
        if (t_cup + 60 > t_ok) t_ok = t_cup + 60;
        #(t_ok - $realtime);
        if (!cas_n) dq = mem[a];
      end
    end
  end
  always @(posedge cas_n) begin
    t_cup = $realtime;
    #7 dq = ~dq;
  end
endmodule // dmsa_mem
`default_nettype wire

// *** dv/dmsa_ctrl_tb.sv ***
`default_nettype none
module dmsa_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic            sys_clk, rst, req_valid, req_write, req_ready, rsp_valid, init_done;
  logic            row_strobe_n, column_strobe_n, write_select_n, data_oe;
  logic [19:0]     req_addr;
  logic [9:0]      shared_address_pins;
  logic [7:0]      req_wdata, rsp_rdata, data_out, dq, rd;
  int              failures, checks_done, cbr_n, n;
  wire logic [7:0] bus_q = data_oe ? data_out : dq;
  dmsa_ctrl #(.PAUSE_CYCLES(25'h14), .REFRESH_CYCLES(25'hC8), .USE_CBR(1'b1)) DUT (.sys_clk, .rst,
    .req_valid, .req_write, .req_addr, .req_wdata, .req_ready, .rsp_valid, .rsp_rdata, .init_done,
    .shared_address_pins, .row_strobe_n, .column_strobe_n, .write_select_n, .data_out, .data_oe,
    .data_in(bus_q));
  dmsa_mem u_mem (.addr(shared_address_pins), .ras_n(row_strobe_n), .cas_n(column_strobe_n),
    .we_n(write_select_n), .din(bus_q), .dq, .cbr_n);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic give_verdict;
    if (failures == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // which: 0 taken pulse, 1 read answer, 2 init done
  task automatic wait_hi(int which);
    n = 0;
    while ((which == 0 ? req_ready : which == 1 ? rsp_valid : init_done) !== 1'b1) begin
      @(negedge sys_clk);
      n++;
      if (n > 2000) begin
        failures++;
        give_verdict;
      end
    end
  endtask
  // requests hold their fields until the taken pulse is seen
  task automatic acc(logic w, logic [19:0] a, logic [7:0] d);
    @(negedge sys_clk);
    req_valid = 1'b1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    wait_hi(0);
    req_valid = 1'b0;
    if (!w) begin
      wait_hi(1);
      rd = rsp_rdata;
    end
  endtask
  task automatic t_init;
    n = 0;
    while ((row_strobe_n & column_strobe_n) === 1'b1 && n < 2000) begin
      @(negedge sys_clk);
      n++;
    end
    chk("pause", 8'h1, 8'(n >= 20));
    wait_hi(2);
    chk("init cycles", 8'h1, 8'(cbr_n >= 8));
  endtask
  task automatic t_rw;
    logic [19:0] a [4] = '{20'h00000, 20'hFFFFF, 20'h003FF, 20'hFFC00};
    logic [7:0]  d [4] = '{8'hFF, 8'h00, 8'hA5, 8'h5A};
    for (int i = 0; i < 4; i++) acc(1'b1, a[i], d[i]);
    for (int i = 0; i < 4; i++) begin
      acc(1'b0, a[i], 8'h00);
      chk("read data", d[i], rd);
    end
  endtask
  task automatic t_refresh;
    int c;
    c = cbr_n;
    repeat (650) @(negedge sys_clk);
    chk("refreshes", 8'h1, 8'(cbr_n - c >= 3));
    acc(1'b0, 20'h003FF, 8'h00);
    chk("kept data", 8'hA5, rd);
  endtask
  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 20'h0;
    req_wdata = 8'h0;
    failures = 0;
    checks_done = 0;
    repeat (2) @(negedge sys_clk);
    chk("reset pins", 8'h1C, {3'h0, row_strobe_n, column_strobe_n, write_select_n, data_oe, init_done});
    rst = 1'b0;
    t_init;
    t_rw;
    t_refresh;
    give_verdict;
  end
endmodule // dmsa_ctrl_tb
`default_nettype wire
